// *** src/pio_defs.svh ***
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH

// ----------------------------------------------------------------------------
// Register word indices, decoded from haddr[4:2].
// ----------------------------------------------------------------------------
`define PIO_CTRL_OFS     3'h0
`define PIO_STATUS_OFS   3'h1
`define PIO_BUCK1_OFS    3'h2
`define PIO_BUCK2_OFS    3'h3
`define PIO_SLEW_OFS     3'h4
`define PIO_VOUT_OFS     3'h5

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define PIO_CTRL_FIRST   0
`define PIO_CTRL_OUT     1
`define PIO_CTRL_THIRD   2
`define PIO_ST_SEL       0
`define PIO_ST_BUF       1
`define PIO_ST_RAIL_EN   2
`define PIO_ST_PG        3
`define PIO_ST_LEVEL     4
`define PIO_ST_DDR_IN    5
`define PIO_ST_RAIL_IN   6
`define PIO_VOUT_TWO_LSB 8

// ----------------------------------------------------------------------------
// Reset values and timing.
// ----------------------------------------------------------------------------
`define PIO_USER_RST     1'h1
`define PIO_BUCK1_DEF    6'h10
`define PIO_BUCK2_DEF    6'h14
`define PIO_SLEW_RST     3'h0
`define PIO_RAMP_LOW     5'h1f

`endif

// *** src/pio_pkg.sv ***
package pio_pkg;

  typedef logic [5:0] pio_volt_type;

  typedef struct packed {
    logic         loaded;
    logic         sel;
    logic         buf_pp;
    logic         rail_en;
    logic         first_user;
    logic         out_user;
    logic         third_user;
    logic         ddr_level;
    logic         rail_sync1;
    logic         rail_sync2;
    logic         rail_prev;
    pio_volt_type buck1;
    pio_volt_type buck2;
    logic [2:0]   slew;
    pio_volt_type vout1;
    pio_volt_type vout2;
    logic [7:0]   ramp_cnt;
    logic         ap_valid;
    logic         ap_write;
    logic [2:0]   ap_idx;
    logic [31:0]  hrdata;
  } pio_state_type;

endpackage

// *** src/pio_pins.sv ***
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`include "pio_defs.svh"


module pio_pins (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic                  nvm_ddr_reset_select,
  input  wire logic                  nvm_out_buffer_type,
  input  wire logic                  nvm_core_rail_reset_enable,
  input  wire logic                  power_good,
  input  wire logic                  seq_first_pin_low,
  input  wire logic                  seq_third_pin_low,
  input  wire logic                  ddr_reset_io_pin_in,
  output logic                       ddr_reset_io_pin_out,
  output logic                       ddr_reset_io_pin_oe_n,
  output logic                       ddr_reset_out_pin_out,
  output logic                       ddr_reset_out_pin_oe_n,
  input  wire logic                  rail_reset_io_pin_in,
  output logic                       rail_reset_io_pin_out,
  output logic                       rail_reset_io_pin_oe_n,
  output pio_pkg::pio_volt_type      core_buck_one_vout,
  output pio_pkg::pio_volt_type      core_buck_two_vout
);
  import pio_pkg::*;

  // --------------------------------------------------------------------------
  // Helper functions.
  // --------------------------------------------------------------------------
  function automatic pio_volt_type ramp_step(input pio_volt_type cur, input pio_volt_type tgt);
    if (cur < tgt) begin
      ramp_step = cur + 6'h01;
    end else if (cur > tgt) begin
      ramp_step = cur - 6'h01;
    end else begin
      ramp_step = cur;
    end
  endfunction

  function automatic logic [31:0] read_reg(input pio_state_type s, input logic [2:0] idx,
                                           input logic pg);
    read_reg = 32'h0000_0000;
    case (idx)
      `PIO_CTRL_OFS: begin
        read_reg[`PIO_CTRL_FIRST] = s.first_user;
        read_reg[`PIO_CTRL_OUT]   = s.out_user;
        read_reg[`PIO_CTRL_THIRD] = s.third_user;
      end
      `PIO_STATUS_OFS: begin
        read_reg[`PIO_ST_SEL]     = s.sel;
        read_reg[`PIO_ST_BUF]     = s.buf_pp;
        read_reg[`PIO_ST_RAIL_EN] = s.rail_en;
        read_reg[`PIO_ST_PG]      = pg;
        read_reg[`PIO_ST_LEVEL]   = s.ddr_level;
        read_reg[`PIO_ST_RAIL_IN] = s.rail_sync2;
      end
      `PIO_BUCK1_OFS: begin
        read_reg[5:0] = s.buck1;
      end
      `PIO_BUCK2_OFS: begin
        read_reg[5:0] = s.buck2;
      end
      `PIO_SLEW_OFS: begin
        read_reg[2:0] = s.slew;
      end
      `PIO_VOUT_OFS: begin
        read_reg[5:0] = s.vout1;
        read_reg[`PIO_VOUT_TWO_LSB +: 6] = s.vout2;
      end
      default: begin
        read_reg = 32'h0000_0000;
      end
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // State and next state.
  // --------------------------------------------------------------------------
  pio_state_type st_reg;
  pio_state_type st_next;
  logic          rail_fall;
  logic          addr_take;
  logic          ramp_tick;
  logic          wr_now;
  logic [31:0]   rd_word;

  assign rail_fall = st_reg.rail_en && st_reg.rail_prev && !st_reg.rail_sync2;
  assign addr_take = hsel && htrans[1] && hready;
  assign ramp_tick = st_reg.ramp_cnt == {st_reg.slew, `PIO_RAMP_LOW};
  assign wr_now    = st_reg.ap_valid && st_reg.ap_write;

  always_comb begin
    st_next = st_reg;
    rd_word = 32'h0000_0000;

    // Configuration is taken once, at the first edge after reset release.
    if (!st_reg.loaded) begin
      st_next.loaded  = 1'b1;
      st_next.sel     = nvm_ddr_reset_select;
      st_next.buf_pp  = nvm_out_buffer_type;
      st_next.rail_en = nvm_core_rail_reset_enable;
    end

    // DDR reset level: pass-through, hold on power-good low, or user bit.
    if (!st_reg.loaded) begin
      st_next.ddr_level = st_reg.ddr_level;
    end else if (st_reg.sel) begin
      if (power_good) begin
        st_next.ddr_level = ddr_reset_io_pin_in;
      end else begin
        st_next.ddr_level = st_reg.ddr_level;
      end
    end else begin
      st_next.ddr_level = st_reg.out_user;
    end

    // Third pin synchroniser and edge history.
    st_next.rail_sync1 = rail_reset_io_pin_in;
    st_next.rail_sync2 = st_reg.rail_sync1;
    st_next.rail_prev  = st_reg.rail_sync2;

    // Register writes in the data phase.
    if (wr_now) begin
      case (st_reg.ap_idx)
        `PIO_CTRL_OFS: begin
          st_next.first_user = hwdata[`PIO_CTRL_FIRST];
          st_next.out_user   = hwdata[`PIO_CTRL_OUT];
          st_next.third_user = hwdata[`PIO_CTRL_THIRD];
        end
        `PIO_BUCK1_OFS: begin
          st_next.buck1 = hwdata[5:0];
        end
        `PIO_BUCK2_OFS: begin
          st_next.buck2 = hwdata[5:0];
        end
        `PIO_SLEW_OFS: begin
          st_next.slew = hwdata[2:0];
        end
        default: begin
          st_next.slew = st_next.slew;
        end
      endcase
    end

    // A rail reset edge wins over a write and touches only the two bucks.
    if (rail_fall) begin
      st_next.buck1 = `PIO_BUCK1_DEF;
      st_next.buck2 = `PIO_BUCK2_DEF;
    end

    // Outputs move one step toward their targets on each ramp tick.
    if (ramp_tick) begin
      st_next.ramp_cnt = 8'h00;
      st_next.vout1    = ramp_step(st_reg.vout1, st_reg.buck1);
      st_next.vout2    = ramp_step(st_reg.vout2, st_reg.buck2);
    end else begin
      st_next.ramp_cnt = st_reg.ramp_cnt + 8'h01;
    end

    // Address phase capture; read data is registered for the data phase.
    st_next.ap_valid = addr_take;
    if (addr_take) begin
      st_next.ap_write = hwrite;
      st_next.ap_idx   = haddr[4:2];
      if (!hwrite) begin
        rd_word = (|haddr[31:5]) ? 32'h0000_0000 : read_reg(st_next, haddr[4:2], power_good);
        st_next.hrdata = rd_word;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg.loaded     <= 1'b0;
      st_reg.sel        <= 1'b0;
      st_reg.buf_pp     <= 1'b0;
      st_reg.rail_en    <= 1'b0;
      st_reg.first_user <= `PIO_USER_RST;
      st_reg.out_user   <= `PIO_USER_RST;
      st_reg.third_user <= `PIO_USER_RST;
      st_reg.ddr_level  <= 1'b0;
      st_reg.rail_sync1 <= 1'b1;
      st_reg.rail_sync2 <= 1'b1;
      st_reg.rail_prev  <= 1'b1;
      st_reg.buck1      <= `PIO_BUCK1_DEF;
      st_reg.buck2      <= `PIO_BUCK2_DEF;
      st_reg.slew       <= `PIO_SLEW_RST;
      st_reg.vout1      <= `PIO_BUCK1_DEF;
      st_reg.vout2      <= `PIO_BUCK2_DEF;
      st_reg.ramp_cnt   <= 8'h00;
      st_reg.ap_valid   <= 1'b0;
      st_reg.ap_write   <= 1'b0;
      st_reg.ap_idx     <= 3'h0;
      st_reg.hrdata     <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  // --------------------------------------------------------------------------
  // Bus answers and pins.
  // --------------------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_reg.hrdata;

  assign ddr_reset_io_pin_out   = 1'b0;
  assign ddr_reset_io_pin_oe_n  = st_reg.sel || (st_reg.first_user && !seq_first_pin_low);
  assign ddr_reset_out_pin_out  = st_reg.buf_pp ? st_reg.ddr_level : 1'b0;
  assign ddr_reset_out_pin_oe_n = st_reg.buf_pp ? 1'b0 : st_reg.ddr_level;
  assign rail_reset_io_pin_out  = 1'b0;
  assign rail_reset_io_pin_oe_n = st_reg.rail_en || (st_reg.third_user && !seq_third_pin_low);
  assign core_buck_one_vout     = st_reg.vout1;
  assign core_buck_two_vout     = st_reg.vout2;

  // --------------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rail_fall;
    st_reg.rail_en && st_reg.rail_sync2 ##1 !st_reg.rail_sync2;
  endsequence

  a_first_pin_od: assert property (st_reg.loaded && !st_reg.sel |->
    ddr_reset_io_pin_oe_n == (st_reg.first_user && !seq_first_pin_low) && !ddr_reset_io_pin_out)
    else $error("first pin open-drain drive wrong");

  a_ddr_pass_thru: assert property (st_reg.loaded && st_reg.sel && power_good |=>
    st_reg.ddr_level == $past(ddr_reset_io_pin_in))
    else $error("ddr reset does not follow first pin");

  a_ddr_hold_low: assert property (st_reg.loaded && st_reg.sel && !power_good |=>
    $stable(st_reg.ddr_level))
    else $error("ddr reset level not held");

  a_ddr_user_bit: assert property (st_reg.loaded && !st_reg.sel |=>
    st_reg.ddr_level == $past(st_reg.out_user))
    else $error("ddr reset output ignores user bit");

  a_buffer_type: assert property (st_reg.buf_pp ?
    (!ddr_reset_out_pin_oe_n && ddr_reset_out_pin_out == st_reg.ddr_level) :
    (ddr_reset_out_pin_oe_n == st_reg.ddr_level && !ddr_reset_out_pin_out))
    else $error("ddr reset buffer type wrong");

  a_sel_ignores_user: assert property (st_reg.loaded && st_reg.sel && $changed(st_reg.out_user)
    && !power_good |=> $stable(st_reg.ddr_level))
    else $error("user bit leaked into ddr reset");

  a_third_pin_od: assert property (!st_reg.rail_en |->
    rail_reset_io_pin_oe_n == (st_reg.third_user && !seq_third_pin_low))
    else $error("third pin open-drain drive wrong");

  a_rail_restore: assert property (s_rail_fall |=>
    st_reg.buck1 == `PIO_BUCK1_DEF && st_reg.buck2 == `PIO_BUCK2_DEF)
    else $error("rail reset did not restore bucks");

  a_rail_keeps_rest: assert property (rail_fall && !wr_now |=>
    $stable(st_reg.slew) && $stable(st_reg.first_user) && $stable(st_reg.third_user))
    else $error("rail reset changed other registers");

  a_ramp_one_step: assert property (!ramp_tick |=> $stable(st_reg.vout1) && $stable(st_reg.vout2))
    else $error("buck output moved off tick");

  a_cfg_fixed: assert property (st_reg.loaded |=>
    $stable(st_reg.sel) && $stable(st_reg.buf_pp) && $stable(st_reg.rail_en))
    else $error("configuration changed while running");

  a_rail_one_pulse: assert property (rail_fall |=> !rail_fall)
    else $error("rail reset pulse longer than one cycle");

  sequence s_pin_low_two;
    !rail_reset_io_pin_in ##1 !rail_reset_io_pin_in;
  endsequence

  a_ddr_start_low: assert property ($rose(st_reg.loaded) |-> !st_reg.ddr_level)
    else $error("ddr reset not low after reset");

  a_sel_pin_input: assert property (st_reg.loaded && st_reg.sel |-> ddr_reset_io_pin_oe_n)
    else $error("first pin driven while used as input");

  a_first_pin_seq: assert property (st_reg.loaded && !st_reg.sel && seq_first_pin_low |->
    !ddr_reset_io_pin_oe_n)
    else $error("sequencer cannot pull first pin low");

  a_third_pin_seq: assert property (!st_reg.rail_en && seq_third_pin_low |-> !rail_reset_io_pin_oe_n)
    else $error("sequencer cannot pull third pin low");

  a_rail_pin_input: assert property (st_reg.rail_en |-> rail_reset_io_pin_oe_n)
    else $error("third pin driven while used as reset input");

  a_rail_off_ignored: assert property (!st_reg.rail_en && !wr_now |=>
    $stable(st_reg.buck1) && $stable(st_reg.buck2))
    else $error("bucks changed with rail reset disabled");

  a_rail_sync_lat: assert property (st_reg.rail_en && rail_reset_io_pin_in ##1 s_pin_low_two |=>
    rail_fall)
    else $error("rail reset edge not detected");

  a_rail_keeps_user: assert property (rail_fall && !wr_now |=>
    $stable(st_reg.out_user) && $stable(st_reg.sel))
    else $error("rail reset changed user or configuration bits");

  a_restore_ramps: assert property (rail_fall && !ramp_tick |=>
    $stable(st_reg.vout1) && $stable(st_reg.vout2))
    else $error("buck output jumped on rail reset");

  a_vout1_rise: assert property (ramp_tick && st_reg.vout1 < st_reg.buck1 |=>
    st_reg.vout1 == $past(st_reg.vout1) + 6'h01)
    else $error("buck one did not step up");

  a_vout1_fall: assert property (ramp_tick && st_reg.vout1 > st_reg.buck1 |=>
    st_reg.vout1 == $past(st_reg.vout1) - 6'h01)
    else $error("buck one did not step down");

  a_vout2_rise: assert property (ramp_tick && st_reg.vout2 < st_reg.buck2 |=>
    st_reg.vout2 == $past(st_reg.vout2) + 6'h01)
    else $error("buck two did not step up");

  a_vout2_fall: assert property (ramp_tick && st_reg.vout2 > st_reg.buck2 |=>
    st_reg.vout2 == $past(st_reg.vout2) - 6'h01)
    else $error("buck two did not step down");

  a_cfg_capture: assert property ($rose(st_reg.loaded) |->
    st_reg.sel == $past(nvm_ddr_reset_select) && st_reg.buf_pp == $past(nvm_out_buffer_type) &&
    st_reg.rail_en == $past(nvm_core_rail_reset_enable))
    else $error("configuration not taken at start");

endmodule

// *** tb/pio_host.sv ***
module pio_host (
  input  wire logic ddr_oe_n,
  input  wire logic drive_en,
  input  wire logic drive_lvl,
  input  wire logic rail_oe_n,
  input  wire logic rail_lvl,
  output logic      ddr_pin,
  output logic      rail_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // The host drives the reset level into the first pin unless the chip pulls it low; the pull-up holds it high when neither drives.
  assign ddr_pin = !ddr_oe_n ? 1'b0 : (drive_en ? drive_lvl : 1'b1);
  assign rail_pin = !rail_oe_n ? 1'b0 : rail_lvl;
endmodule

// *** tb/tb.sv ***
`include "pio_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hresp, sel = 0, bt = 0, ren = 0, pg = 0, sq1 = 0, sq3 = 0, den = 0, dlv = 1, rlv = 1;
  logic io_in, io_out, io_oe_n, o_out, o_oe_n, r_in, r_out, r_oe_n;
  pio_pkg::pio_volt_type v1, v2;
  int err_total = 0, total_checks = 0, cyc = 0;
  wire logic [3:0] pins = {io_oe_n, o_out, o_oe_n, r_oe_n};

  always #5 hclk = ~hclk;

  pio_pins dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .nvm_ddr_reset_select(sel), .nvm_out_buffer_type(bt),
    .nvm_core_rail_reset_enable(ren), .power_good(pg), .seq_first_pin_low(sq1),
    .seq_third_pin_low(sq3), .ddr_reset_io_pin_in(io_in), .ddr_reset_io_pin_out(io_out),
    .ddr_reset_io_pin_oe_n(io_oe_n), .ddr_reset_out_pin_out(o_out), .ddr_reset_out_pin_oe_n(o_oe_n),
    .rail_reset_io_pin_in(r_in), .rail_reset_io_pin_out(r_out), .rail_reset_io_pin_oe_n(r_oe_n),
    .core_buck_one_vout(v1), .core_buck_two_vout(v2));

  pio_host host (.ddr_oe_n(io_oe_n), .drive_en(den), .drive_lvl(dlv), .rail_oe_n(r_oe_n),
    .rail_lvl(rlv), .ddr_pin(io_in), .rail_pin(r_in));

  // ---------------------------------------------------------------------------
  // Bus and check tasks.
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] ad(input logic [2:0] i);
    return {27'h0, i, 2'h0};
  endfunction

  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [2:0] i, input logic [31:0] exp);
    xfer(ad(i), 0, 0);
    chk(d, exp);
  endtask

  task automatic rst(input logic s, input logic b, input logic r);
    sel <= s;
    bt <= b;
    ren <= r;
    hresetn <= 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    repeat (2) @(posedge hclk);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 12000) begin
      err_total++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------------------
  // Tests.
  // ---------------------------------------------------------------------------
  initial begin
    rst(0, 0, 0);
    rd(`PIO_CTRL_OFS, 32'h7);
    rd(`PIO_BUCK1_OFS, 32'h10);
    rd(`PIO_BUCK2_OFS, 32'h14);
    xfer(32'h40, 0, 0);
    chk(d, 32'h0);
    xfer(ad(`PIO_CTRL_OFS), 1, 32'h0);
    repeat (2) @(posedge hclk);
    chk(32'(pins), 32'h0);
    chk(32'({hresp, io_out, r_out}), 32'h0);
    xfer(ad(`PIO_CTRL_OFS), 1, 32'h7);
    repeat (2) @(posedge hclk);
    chk(32'(pins), 32'hb);
    sq1 <= 1;
    sq3 <= 1;
    repeat (2) @(posedge hclk);
    chk(32'(pins), 32'h2);
    sq1 <= 0;
    sq3 <= 0;
    xfer(ad(`PIO_BUCK1_OFS), 1, 32'h5);
    rlv <= 0;
    repeat (6) @(posedge hclk);
    rlv <= 1;
    rd(`PIO_BUCK1_OFS, 32'h5);
    $display("test open drain outputs done");

    rst(1, 1, 1);
    sel <= 0;
    bt <= 0;
    ren <= 0;
    xfer(ad(`PIO_STATUS_OFS), 0, 0);
    chk(32'(d[2:0]), 32'h7);
    chk(d, 32'h47);
    chk(32'(pins), 32'h9);
    den <= 1;
    pg <= 1;
    repeat (3) @(posedge hclk);
    chk(32'(pins), 32'hd);
    dlv <= 0;
    repeat (3) @(posedge hclk);
    chk(32'(pins), 32'h9);
    dlv <= 1;
    repeat (3) @(posedge hclk);
    pg <= 0;
    repeat (2) @(posedge hclk);
    dlv <= 0;
    xfer(ad(`PIO_CTRL_OFS), 1, 32'h0);
    repeat (3) @(posedge hclk);
    chk(32'(pins), 32'hd);
    $display("test ddr reset path done");

    xfer(ad(`PIO_SLEW_OFS), 1, 32'h1);
    xfer(ad(`PIO_BUCK1_OFS), 1, 32'h5);
    xfer(ad(`PIO_BUCK2_OFS), 1, 32'h7);
    repeat (1000) @(posedge hclk);
    chk(32'(v1), 32'h5);
    rd(`PIO_VOUT_OFS, 32'h705);
    rlv <= 0;
    repeat (5) @(posedge hclk);
    rd(`PIO_BUCK1_OFS, 32'h10);
    rd(`PIO_BUCK2_OFS, 32'h14);
    rd(`PIO_SLEW_OFS, 32'h1);
    rd(`PIO_CTRL_OFS, 32'h0);
    chk(32'(v1 < 6'h8), 32'h1);
    xfer(ad(`PIO_BUCK1_OFS), 1, 32'h9);
    repeat (5) @(posedge hclk);
    rd(`PIO_BUCK1_OFS, 32'h9);
    xfer(ad(`PIO_BUCK1_OFS), 1, 32'h10);
    repeat (1100) @(posedge hclk);
    chk(32'(v1), 32'h10);
    chk(32'(v2), 32'h14);
    rlv <= 1;
    $display("test rail reset done");

    den <= 0;
    rst(1, 0, 0);
    chk(32'(pins), 32'h9);
    den <= 1;
    dlv <= 1;
    pg <= 1;
    repeat (3) @(posedge hclk);
    chk(32'(pins), 32'hb);
    $display("test open drain ddr output done");
    print_verdict();
  end
endmodule
